// *** rtl/asc_pkg.sv ***
// constants and types shared by the static ram controller
package asc_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 40;
	// timing figures in their own units
	localparam int T_READ_CYCLE_NS = 70;
	localparam int T_OUT_HOLD_NS = 10;
	localparam int T_OE_FLOAT_NS = 25;
	localparam int T_WRITE_CYCLE_NS = 70;
	localparam int T_WRITE_PULSE_NS = 50;
	localparam int T_ADDR_TO_END_NS = 55;
	localparam int T_SEL_TO_END_NS = 55;
	localparam int T_DATA_TO_END_NS = 35;
	localparam int T_WE_FLOAT_NS = 25;
	localparam int T_WRITE_RECOV_NS = 5;
	localparam int T_RECOVERY_MS = 5;
	localparam int NS_PER_MS = 1000000;
	// flops between the data pins and the sequencer
	localparam int SYNC_DEPTH = 3;
	// cycle counts: least times round up
	localparam int RD_CYC = (T_READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AW_CYC = (T_ADDR_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CW_CYC = (T_SEL_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DW_CYC = (T_DATA_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FL_CYC = (T_OE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WC_CYC = (T_WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_CYC = (T_WRITE_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOV_CYC = (T_RECOVERY_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CNT_W = 18;
	localparam logic [CNT_W-1:0] CNT_ZERO = 18'h0_0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 18'h0_0001;
	typedef enum logic [6:0] {
		S_IDLE = 7'b000_0001,
		S_RD = 7'b000_0010,
		S_RFLT = 7'b000_0100,
		S_WSET = 7'b000_1000,
		S_WPUL = 7'b001_0000,
		S_WREC = 7'b010_0000,
		S_RET = 7'b100_0000
	} asc_state_t;
endpackage

// *** rtl/asc_ctrl.sv ***
// host controller driving an asynchronous 128k x 8 static ram
`timescale 1ns/1ps
module asc_ctrl import asc_pkg::*; #(
	parameter int RECOVERY_CYCLES = RECOV_CYC
) (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// request side
	input wire logic REQ_VALID,
	input wire logic REQ_WRITE,
	input wire logic [asc_pkg::ADDR_W-1:0] REQ_ADDR,
	input wire logic [asc_pkg::DATA_W-1:0] REQ_WDATA,
	output logic REQ_READY,
	output logic [asc_pkg::DATA_W-1:0] RD_DATA,
	output logic RD_VALID,
	// retention control
	input wire logic RET_ENTER,
	input wire logic RET_EXIT,
	output logic IN_RETENTION,
	// memory pins
	output logic [asc_pkg::ADDR_W-1:0] MEM_ADDR,
	output logic MEM_SEL_LOW_N,
	output logic MEM_SEL_HIGH,
	output logic MEM_WE_N,
	output logic MEM_OE_N,
	output logic [asc_pkg::DATA_W-1:0] MEM_DQ_O,
	output logic MEM_DQ_OE_N,
	input wire logic [asc_pkg::DATA_W-1:0] MEM_DQ_I
);
	import asc_pkg::*;

	asc_state_t st_ff, nxt_st;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
	logic rdv_ff, nxt_rdv, sel_ff, nxt_sel, we_n_ff, nxt_we_n;
	logic oe_n_ff, nxt_oe_n, drv_ff, nxt_drv;
	logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;
	logic recov_ff, nxt_recov;

	//////////////////////////////////////////////////////////////////////
	// data pin input synchroniser
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			dq_s1_ff <= '0;
			dq_s2_ff <= '0;
			dq_s3_ff <= '0;
		end else begin
			dq_s1_ff <= MEM_DQ_I;
			dq_s2_ff <= dq_s1_ff;
			dq_s3_ff <= dq_s2_ff;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// access sequencer
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = (cnt_ff == CNT_ZERO) ? CNT_ZERO : cnt_ff - CNT_ONE;
		nxt_addr = addr_ff;
		nxt_wd = wd_ff;
		nxt_rd = rd_ff;
		nxt_rdv = 1'b0;
		nxt_sel = sel_ff;
		nxt_we_n = we_n_ff;
		nxt_oe_n = oe_n_ff;
		nxt_drv = drv_ff;
		nxt_recov = recov_ff;
		case (st_ff)
			S_IDLE: begin
				nxt_sel = 1'b0;
				nxt_we_n = 1'b1;
				nxt_oe_n = 1'b1;
				nxt_drv = 1'b0;
				if (recov_ff) begin
					if (cnt_ff == CNT_ZERO)
						nxt_recov = 1'b0;
				end else if (RET_ENTER) begin
					nxt_st = S_RET;
				end else if (REQ_VALID) begin
					nxt_addr = REQ_ADDR;
					nxt_wd = REQ_WDATA;
					nxt_sel = 1'b1;
					if (REQ_WRITE) begin
						nxt_st = S_WSET;
						nxt_cnt = CNT_W'(CW_CYC > AW_CYC ? CW_CYC : AW_CYC);
					end else begin
						nxt_st = S_RD;
						nxt_oe_n = 1'b0;
						// pins sampled three flops late, so hold longer
						nxt_cnt = CNT_W'(RD_CYC + SYNC_DEPTH);
					end
				end
			end
			S_RD: begin
				if (cnt_ff == CNT_ONE) begin
					nxt_rd = dq_s3_ff;
					nxt_rdv = 1'b1;
					nxt_oe_n = 1'b1;
					nxt_sel = 1'b0;
					nxt_cnt = CNT_W'(FL_CYC);
					nxt_st = S_RFLT;
				end
			end
			S_RFLT: begin
				if (cnt_ff == CNT_ZERO)
					nxt_st = S_IDLE;
			end
			S_WSET: begin
				// selects stable first, strobe falls next
				nxt_we_n = 1'b0;
				nxt_cnt = CNT_W'(WP_CYC > FL_CYC ? WP_CYC : FL_CYC + 1);
				nxt_st = S_WPUL;
			end
			S_WPUL: begin
				// host drives once ram has floated after strobe fell
				if (cnt_ff <= CNT_W'(WP_CYC - DW_CYC + 1))
					nxt_drv = 1'b1;
				if (cnt_ff == CNT_ONE) begin
					nxt_we_n = 1'b1;
					nxt_cnt = CNT_W'(WR_CYC + (WC_CYC > WP_CYC + 2 ? 1 : 0));
					nxt_st = S_WREC;
				end
			end
			S_WREC: begin
				nxt_drv = 1'b0;
				nxt_sel = 1'b0;
				if (cnt_ff == CNT_ZERO)
					nxt_st = S_IDLE;
			end
			S_RET: begin
				nxt_sel = 1'b0;
				if (RET_EXIT) begin
					nxt_recov = 1'b1;
					nxt_cnt = CNT_W'(RECOVERY_CYCLES);
					nxt_st = S_IDLE;
				end
			end
			default: nxt_st = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			st_ff <= S_IDLE;
			cnt_ff <= CNT_ZERO;
			addr_ff <= '0;
			wd_ff <= '0;
			rd_ff <= '0;
			rdv_ff <= 1'b0;
			sel_ff <= 1'b0;
			we_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			drv_ff <= 1'b0;
			recov_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			addr_ff <= nxt_addr;
			wd_ff <= nxt_wd;
			rd_ff <= nxt_rd;
			rdv_ff <= nxt_rdv;
			sel_ff <= nxt_sel;
			we_n_ff <= nxt_we_n;
			oe_n_ff <= nxt_oe_n;
			drv_ff <= nxt_drv;
			recov_ff <= nxt_recov;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// outputs
	assign REQ_READY = (st_ff == S_IDLE) && !recov_ff && !RET_ENTER;
	assign RD_DATA = rd_ff;
	assign RD_VALID = rdv_ff;
	assign IN_RETENTION = (st_ff == S_RET);
	assign MEM_ADDR = addr_ff;
	assign MEM_SEL_LOW_N = !sel_ff;
	assign MEM_SEL_HIGH = sel_ff;
	assign MEM_WE_N = we_n_ff;
	assign MEM_OE_N = oe_n_ff;
	assign MEM_DQ_O = wd_ff;
	assign MEM_DQ_OE_N = !drv_ff;

	//////////////////////////////////////////////////////////////////////
	// checks
	sequence s_strobe_fall;
		$fell(MEM_WE_N);
	endsequence
	a_no_drive_read: assert property (@(posedge CLK) disable iff (!NRST)
		!MEM_DQ_OE_N |-> MEM_OE_N && $past(MEM_OE_N))
		else $error("host drives data while ram may drive");
	a_we_high_read: assert property (@(posedge CLK) disable iff (!NRST)
		!MEM_OE_N |-> MEM_WE_N)
		else $error("strobe low during read");
	a_sel_before_we: assert property (@(posedge CLK) disable iff (!NRST)
		s_strobe_fall |-> $past(MEM_SEL_HIGH) && !$past(MEM_SEL_LOW_N))
		else $error("select not active before strobe fell");
	a_pulse_width: assert property (@(posedge CLK) disable iff (!NRST)
		s_strobe_fall |-> !MEM_WE_N [*2])
		else $error("write pulse too short");
	a_addr_stable: assert property (@(posedge CLK) disable iff (!NRST)
		$changed(MEM_ADDR) |-> MEM_WE_N || MEM_SEL_LOW_N || !MEM_SEL_HIGH)
		else $error("address moved during access");
	a_data_setup: assert property (@(posedge CLK) disable iff (!NRST)
		$rose(MEM_WE_N) |-> !$past(MEM_DQ_OE_N))
		else $error("data not present before write end");
	a_read_space: assert property (@(posedge CLK) disable iff (!NRST)
		$fell(MEM_OE_N) |=> !MEM_OE_N [*2])
		else $error("read cycle too short");
	a_gate_float: assert property (@(posedge CLK) disable iff (!NRST)
		$rose(MEM_OE_N) |-> MEM_DQ_OE_N [*2])
		else $error("host drove before ram floated");
	a_retain_desel: assert property (@(posedge CLK) disable iff (!NRST)
		IN_RETENTION |-> !MEM_SEL_HIGH && MEM_SEL_LOW_N)
		else $error("selected during retention");
	a_recov_block: assert property (@(posedge CLK) disable iff (!NRST)
		$fell(IN_RETENTION) |=> !REQ_READY [*3])
		else $error("access allowed during recovery");
endmodule

// *** sim/asc_sram_model.sv ***
// behavioural model of the 128k x 8 static ram
`timescale 1ns/1ps
module asc_sram_model import asc_pkg::*; (
	// memory pins
	input wire logic [asc_pkg::ADDR_W-1:0] addr,
	input wire logic sel_low_n,
	input wire logic sel_high,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [asc_pkg::DATA_W-1:0] din,
	// data pins out
	output logic [asc_pkg::DATA_W-1:0] dout,
	output logic drive
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] last = 8'h00;
	logic sel;
	assign sel = !sel_low_n && sel_high;
	// pins float unless selected, gate low and strobe high
	assign drive = sel && !oe_n && we_n;
	// released pins show the inverse of the last value
	assign dout = drive ? mem[addr] : ~last;
	always @* begin
		if (drive)
			last = mem[addr];
	end
	// stores only during the overlap of both selects and strobe
	always @* begin
		if (sel && !we_n)
			mem[addr] = din;
	end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the static ram controller
`timescale 1ns/1ps
module testbench;
	import asc_pkg::*;
	localparam int REC = 10;
	logic CLK = 0, NRST = 0, REQ_VALID = 0, REQ_WRITE = 0;
	logic RET_ENTER = 0, RET_EXIT = 0;
	logic [ADDR_W-1:0] REQ_ADDR = '0, addr, a_q;
	logic [DATA_W-1:0] REQ_WDATA = '0, RD_DATA, dq_o, mem_o, bus;
	logic REQ_READY, RD_VALID, IN_RETENTION, SEL_LOW_N, SEL_HIGH;
	logic WE_N, OE_N, DQ_OE_N, drive;
	int err_total = 0, comparisons = 0;
	assign bus = !DQ_OE_N ? dq_o : mem_o;
	asc_ctrl #(.RECOVERY_CYCLES(REC)) dut_u (.CLK(CLK), .NRST(NRST),
		.REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
		.REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
		.REQ_READY(REQ_READY), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
		.RET_ENTER(RET_ENTER), .RET_EXIT(RET_EXIT),
		.IN_RETENTION(IN_RETENTION), .MEM_ADDR(addr),
		.MEM_SEL_LOW_N(SEL_LOW_N), .MEM_SEL_HIGH(SEL_HIGH),
		.MEM_WE_N(WE_N), .MEM_OE_N(OE_N), .MEM_DQ_O(dq_o),
		.MEM_DQ_OE_N(DQ_OE_N), .MEM_DQ_I(bus));
	asc_sram_model mem_u (.addr(addr), .sel_low_n(SEL_LOW_N),
		.sel_high(SEL_HIGH), .we_n(WE_N), .oe_n(OE_N), .din(bus),
		.dout(mem_o), .drive(drive));
	initial forever #20 CLK = ~CLK;
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// pin discipline watched on every rising edge
	always @(posedge CLK) begin
		if (NRST && drive && !DQ_OE_N)
			chk("contention", 8'h00, 8'h01);
		if (NRST && !OE_N && WE_N !== 1'b1)
			chk("strobe in read", 8'h01, 8'(WE_N));
		if (NRST && !WE_N && addr !== a_q)
			chk("addr in write", 8'h00, 8'h01);
		a_q <= addr;
	end
	task automatic req(logic w, logic [ADDR_W-1:0] a, logic [7:0] d);
		int n = 0;
		@(posedge CLK);
		#1 REQ_VALID = 1;
		REQ_WRITE = w;
		REQ_ADDR = a;
		REQ_WDATA = d;
		// ready only moves at edges, so look just after one
		while (REQ_READY !== 1'b1 && n < 50) begin
			@(posedge CLK);
			#1 n++;
		end
		@(posedge CLK);
		#1 REQ_VALID = 0;
		chk("request taken", 8'h01, 8'(n < 50));
	endtask
	task automatic rd(logic [ADDR_W-1:0] a, logic [7:0] e);
		int n = 0;
		req(1'b0, a, 8'h00);
		while (RD_VALID !== 1'b1 && n < 20) begin
			@(posedge CLK);
			#1 n++;
		end
		chk("read valid", 8'h01, 8'(RD_VALID));
		chk("read data", e, RD_DATA);
	endtask
	task automatic t_idle;
		chk("low select", 8'h01, 8'(SEL_LOW_N));
		chk("high select", 8'h00, 8'(SEL_HIGH));
		chk("strobe", 8'h01, 8'(WE_N));
		chk("gate", 8'h01, 8'(OE_N));
		chk("data drive", 8'h01, 8'(DQ_OE_N));
		$display("test idle done");
	endtask
	task automatic t_data;
		logic [ADDR_W-1:0] at [3] = '{17'h0_0000, 17'h1_FFFF, 17'h0_A5A5};
		logic [7:0] dt [3] = '{8'h5A, 8'hC3, 8'h0F};
		for (int i = 0; i < 3; i++)
			req(1'b1, at[i], dt[i]);
		for (int i = 0; i < 3; i++)
			rd(at[i], dt[i]);
		$display("test data done");
	endtask
	task automatic t_ret;
		int n = 0;
		// retention is only entered from idle, so hold the request
		RET_ENTER = 1;
		while (IN_RETENTION !== 1'b1 && n < 20) begin
			@(posedge CLK);
			#1 n++;
		end
		RET_ENTER = 0;
		chk("in retention", 8'h01, 8'(IN_RETENTION));
		chk("high select", 8'h00, 8'(SEL_HIGH));
		chk("low select", 8'h01, 8'(SEL_LOW_N));
		RET_EXIT = 1;
		@(posedge CLK);
		#1 RET_EXIT = 0;
		n = 0;
		while (REQ_READY !== 1'b1 && n < 100) begin
			@(posedge CLK);
			#1 n++;
		end
		chk("recovery wait", 8'h01, 8'(n >= REC));
		chk("recovery end", 8'h01, 8'(n < 100));
		rd(17'h1_FFFF, 8'hC3);
		$display("test retention done");
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge CLK);
		#1 NRST = 1;
		t_idle;
		t_data;
		t_ret;
		end_of_test;
	end
endmodule
